// >>> common/charger_state_params.svh
// Constants for the charger state control block
`ifndef CHARGER_STATE_PARAMS_SVH
`define CHARGER_STATE_PARAMS_SVH
`define CLK_HZ            20000000
`define DEBOUNCE_US       32
`define DEBOUNCE_CYC      ((`DEBOUNCE_US * (`CLK_HZ / 1000000)))
`define DTL_PRE           8'h00
`define DTL_CC            8'h01
`define DTL_CV            8'h02
`define DTL_TOPOFF        8'h03
`define DTL_DONE          8'h04
`define DTL_TFAULT        8'h06
`define DTL_WDOG          8'h07
`define DTL_OFF           8'h08
`define DTL_TSHDN         8'h0a
`define MODE_DEFAULT      4'h5
`define MODE_CHARGE       4'h5
`define WDOG_CLEAR_CODE   2'h1
`define WARM_DROP_MV      16'h00b4
`define DEBOUNCE_W        12
`endif

// >>> common/charger_state_pkg.sv
// Types for the charger state control block
package charger_state_pkg;
  typedef enum logic [3:0] {
    ST_OFF     = 4'b0000,
    ST_PRE     = 4'b0001,
    ST_TRICKLE = 4'b0010,
    ST_CC      = 4'b0011,
    ST_CV      = 4'b0100,
    ST_TOPOFF  = 4'b0101,
    ST_DONE    = 4'b0110,
    ST_TFAULT  = 4'b0111,
    ST_WDOG    = 4'b1000,
    ST_TSHDN   = 4'b1001,
    ST_SHIP    = 4'b1010
  } chg_state_t;
  typedef enum logic [1:0] {
    PH_PRECHARGE = 2'b00,
    PH_TRICKLE   = 2'b01,
    PH_FAST      = 2'b10
  } cur_phase_t;
endpackage

// >>> design/charger_state_control.sv
// Charger control state machine with timers and status reporting
`timescale 1ns/10ps
`include "charger_state_params.svh"

// Contract
// - Enter top-off from CV on low current
// - Top-off duration elapsed goes to done
// - Restart threshold returns to CC fast charge
// - Watchdog expiry from top-off/done suspends
// - Done reports 0x04, good cleared, current zero
// - Prequal, fast, top-off time limits
// - Timer fault immediate event, code 0x06
// - Timer fault exit by mode, pin, input
// - Watchdog disabled at reset, enable bit starts
// - Watchdog expiry stops charge, clear restarts
// - Thermal shutdown clears good, code 0x0A
// - Thermal shutdown resets mode field defaults
// - Thermal shutdown exits with 15C hysteresis
// - Foldback edges raise event, status readable
// - Temperature profile on unless enable cleared
// - Cool band settings, warm band voltage drop
// - Suspend charge when cold or hot
// - Halved current doubles charge timer limit
// - Ship mode entry on battery only
// - Ship exit re-enables serial, conditional charge
// - Phase current chosen by battery voltage
// - Precharge/trickle 0x00, CC 0x01, CV 0x02
// - Off state zeroes timers, reports 0x08
module charger_state_control #(
  parameter int unsigned TIMER_W      = 32,
  parameter int unsigned PQ_CYCLES    = 32'd600000000,
  parameter int unsigned FC_UNIT      = 32'd600000000,
  parameter int unsigned TO_UNIT      = 32'd120000000,
  parameter int unsigned WD_CYCLES    = 32'd1600000000,
  parameter int unsigned DEBOUNCE_CYC = `DEBOUNCE_CYC
) (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        inputValid,
  input  wire logic [3:0]  modeWrData,
  input  wire logic        modeWrStrobe,
  input  wire logic        battery_disconnect_pin,
  input  wire logic        ship_mode_request,
  input  wire logic        host_timer_enable,
  input  wire logic        hostTimerEnWr,
  input  wire logic [1:0]  host_timer_clear,
  input  wire logic        hostTimerClrWr,
  input  wire logic        prequal_phase_enable,
  input  wire logic        battery_temp_control_enable,
  input  wire logic        batteryTempEnWr,
  input  wire logic [2:0]  fast_charge_time_limit_sel,
  input  wire logic [2:0]  topoff_duration_sel,
  input  wire logic [7:0]  cool_band_current_sel,
  input  wire logic [15:0] primary_regulation_voltage_sel,
  input  wire logic [15:0] cool_band_voltage_sel,
  input  wire logic        vbatBelowPrechg,
  input  wire logic        vbatBelowSysMin,
  input  wire logic        vbatAboveReg,
  input  wire logic        vbatBelowRestart,
  input  wire logic        currentBelowTopoff,
  input  wire logic        tjOverShutdown,
  input  wire logic        tjBelowHysteresis,
  input  wire logic        thermalFoldbackActive,
  input  wire logic [2:0]  tempBand,
  output logic             charger_event_flag,
  output logic             charger_good_flag,
  output logic [7:0]       charger_detail_code,
  output logic [2:0]       thermistor_detail_code,
  output logic             thermal_regulation_flag,
  output logic [3:0]       modeField,
  output logic             hostTimerEnabled,
  output logic             battery_temp_control_enable_q,
  output logic             chargeEnable,
  output logic [1:0]       currentPhase,
  output logic             useCoolSettings,
  output logic [7:0]       fastCurrentSel,
  output logic [15:0]      regVoltageTarget,
  output logic             serialEnable,
  output logic             shipMode
);
  // ---------------------------------------------------------------
  // Combinational decode
  // ---------------------------------------------------------------
  charger_state_pkg::chg_state_t stateQ, stateD;
  logic [TIMER_W-1:0]    chgTimerQ, wdTimerQ;
  logic [31:0]           dbCntQ;
  logic [3:0]            modeQ;
  logic                  wdEnQ, tempEnQ, pinQ, pinSeenHighQ, foldQ, prevModeOffQ;

  // Band codes: 0 normal, 1 cold, 2 cool, 3 warm, 4 hot
  wire tooCold  = tempEnQ && (tempBand == 3'h1);
  wire coolBand = tempEnQ && (tempBand == 3'h2);
  wire warmBand = tempEnQ && (tempBand == 3'h3);
  wire tooHot   = tempEnQ && (tempBand == 3'h4);
  wire tempSuspend = tooCold || tooHot;
  wire halfCurrent = coolBand;
  wire chargerOn = inputValid && (modeQ == `MODE_CHARGE) && !pinQ;
  wire clearWrite = hostTimerClrWr && (host_timer_clear == `WDOG_CLEAR_CODE);
  wire wdExpired = wdEnQ && (wdTimerQ >= TIMER_W'(WD_CYCLES));
  wire inPrequal = (stateQ == charger_state_pkg::ST_PRE) ||
                   (stateQ == charger_state_pkg::ST_TRICKLE);
  wire inFast    = (stateQ == charger_state_pkg::ST_CC) ||
                   (stateQ == charger_state_pkg::ST_CV);
  wire inTopoff  = stateQ == charger_state_pkg::ST_TOPOFF;

  function automatic logic [TIMER_W-1:0] scaled(input logic [2:0] sel,
                                                input int unsigned unit);
    scaled = TIMER_W'((sel + 3'h1) * unit);
  endfunction

  wire [TIMER_W-1:0] fcBase  = scaled(fast_charge_time_limit_sel, FC_UNIT);
  wire [TIMER_W-1:0] fcLimit = halfCurrent ? TIMER_W'({fcBase, 1'b0}) : fcBase;
  wire [TIMER_W-1:0] pqLimit = halfCurrent ? TIMER_W'({PQ_CYCLES, 1'b0})
                                           : TIMER_W'(PQ_CYCLES);
  wire [TIMER_W-1:0] toLimit = scaled(topoff_duration_sel, TO_UNIT);
  wire timeoutPq = inPrequal && (chgTimerQ >= pqLimit);
  wire timeoutFc = inFast && (chgTimerQ >= fcLimit);
  wire topoffDone = inTopoff && (chgTimerQ >= toLimit);

  // Timer fault exit: mode off-then-on, pin L-H-L, or input removal
  wire modeOffNow = modeQ != `MODE_CHARGE;
  wire faultExit = (prevModeOffQ && !modeOffNow) ||
                   (pinSeenHighQ && !battery_disconnect_pin) || !inputValid;

  // Current-phase selection by voltage
  wire [1:0] phase = vbatBelowPrechg ? 2'(charger_state_pkg::PH_PRECHARGE) :
                     vbatBelowSysMin ? 2'(charger_state_pkg::PH_TRICKLE) :
                                       2'(charger_state_pkg::PH_FAST);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    stateD = stateQ;
    unique case (stateQ)
      charger_state_pkg::ST_TSHDN:
        if (tjBelowHysteresis) stateD = charger_state_pkg::ST_OFF;
      charger_state_pkg::ST_SHIP:
        if (inputValid) stateD = charger_state_pkg::ST_OFF;
      charger_state_pkg::ST_TFAULT:
        if (faultExit) stateD = charger_state_pkg::ST_OFF;
      charger_state_pkg::ST_OFF:
        if (!inputValid && (battery_disconnect_pin || ship_mode_request)) begin
          stateD = charger_state_pkg::ST_SHIP;
        end else if (chargerOn && !tempSuspend) begin
          stateD = (phase == 2'(charger_state_pkg::PH_PRECHARGE)) ?
                   charger_state_pkg::ST_PRE :
                   (phase == 2'(charger_state_pkg::PH_TRICKLE) && prequal_phase_enable) ?
                   charger_state_pkg::ST_TRICKLE : charger_state_pkg::ST_CC;
        end
      charger_state_pkg::ST_WDOG:
        if (clearWrite) stateD = charger_state_pkg::ST_OFF;
      charger_state_pkg::ST_PRE:
        if (timeoutPq) stateD = charger_state_pkg::ST_TFAULT;
        else if (!vbatBelowPrechg) stateD = charger_state_pkg::ST_TRICKLE;
      charger_state_pkg::ST_TRICKLE:
        if (timeoutPq) stateD = charger_state_pkg::ST_TFAULT;
        else if (!vbatBelowSysMin || !prequal_phase_enable) stateD = charger_state_pkg::ST_CC;
      charger_state_pkg::ST_CC:
        if (timeoutFc) stateD = charger_state_pkg::ST_TFAULT;
        else if (vbatAboveReg) stateD = charger_state_pkg::ST_CV;
      charger_state_pkg::ST_CV:
        if (timeoutFc) stateD = charger_state_pkg::ST_TFAULT;
        else if (currentBelowTopoff) stateD = charger_state_pkg::ST_TOPOFF;
      charger_state_pkg::ST_TOPOFF:
        if (vbatBelowRestart) stateD = charger_state_pkg::ST_CC;
        else if (topoffDone) stateD = charger_state_pkg::ST_DONE;
      charger_state_pkg::ST_DONE:
        if (vbatBelowRestart) stateD = charger_state_pkg::ST_CC;
      default:
        stateD = charger_state_pkg::ST_OFF;
    endcase
    // Charging states share the global exits
    if (stateQ inside {charger_state_pkg::ST_PRE, charger_state_pkg::ST_TRICKLE,
                       charger_state_pkg::ST_CC, charger_state_pkg::ST_CV,
                       charger_state_pkg::ST_TOPOFF, charger_state_pkg::ST_DONE}) begin
      if (wdExpired) stateD = charger_state_pkg::ST_WDOG;
      if (!chargerOn || tempSuspend) stateD = charger_state_pkg::ST_OFF;
    end
    if (stateQ inside {charger_state_pkg::ST_WDOG} && !chargerOn)
      stateD = charger_state_pkg::ST_OFF;
    if (tjOverShutdown && stateQ != charger_state_pkg::ST_SHIP)
      stateD = charger_state_pkg::ST_TSHDN;
  end

  wire stateChange = stateD != stateQ;
  wire enterFault  = stateChange && (stateD == charger_state_pkg::ST_TFAULT);
  wire enterStop   = stateChange && ((stateD == charger_state_pkg::ST_WDOG) ||
                                     (stateD == charger_state_pkg::ST_TSHDN));
  wire dbDone = !stateChange && (dbCntQ == DEBOUNCE_CYC - 1);
  logic [7:0] dbCode;
  logic       dbGood;
  always_comb begin
    dbGood = 1'b1;
    unique case (stateQ)
      charger_state_pkg::ST_CC:     dbCode = `DTL_CC;
      charger_state_pkg::ST_CV:     dbCode = `DTL_CV;
      charger_state_pkg::ST_TOPOFF: dbCode = `DTL_TOPOFF;
      charger_state_pkg::ST_DONE: begin
        dbCode = `DTL_DONE;
        dbGood = 1'b0;
      end
      charger_state_pkg::ST_OFF:    dbCode = `DTL_OFF;
      default:                      dbCode = `DTL_PRE;
    endcase
  end
  wire dbUpdate = dbDone && inputValid && !(stateQ inside {charger_state_pkg::ST_TFAULT,
                  charger_state_pkg::ST_WDOG, charger_state_pkg::ST_TSHDN,
                  charger_state_pkg::ST_SHIP});
  wire dbOffUpdate = dbDone && stateQ == charger_state_pkg::ST_OFF;
  wire foldEdge = thermalFoldbackActive != foldQ;
  wire dbEvent = (dbUpdate || dbOffUpdate) && !charger_good_flag;
  wire stopEvent = enterStop && charger_good_flag;
  wire chargingNext = stateD inside {charger_state_pkg::ST_PRE, charger_state_pkg::ST_TRICKLE,
                      charger_state_pkg::ST_CC, charger_state_pkg::ST_CV,
                      charger_state_pkg::ST_TOPOFF};

  // ---------------------------------------------------------------
  // State, timers and configuration
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stateQ <= charger_state_pkg::ST_OFF;
      dbCntQ <= 32'h0;
      chgTimerQ <= '0;
      wdTimerQ <= '0;
      modeQ <= `MODE_DEFAULT;
      wdEnQ <= 1'b0;
      tempEnQ <= 1'b1;
      pinQ <= 1'b0;
      pinSeenHighQ <= 1'b0;
      foldQ <= 1'b0;
      prevModeOffQ <= 1'b0;
    end else begin
      stateQ <= stateD;
      // Counter parks past its end so one stay in a state reports once
      dbCntQ <= stateChange ? 32'h0 :
                (dbCntQ == DEBOUNCE_CYC) ? dbCntQ : dbCntQ + 32'h1;
      pinQ <= battery_disconnect_pin;
      foldQ <= thermalFoldbackActive;
      // Timer restarts on phase change; CC and CV share one budget
      if (stateD == charger_state_pkg::ST_OFF || (stateChange &&
          !(stateQ == charger_state_pkg::ST_CC && stateD == charger_state_pkg::ST_CV)))
        chgTimerQ <= '0;
      else
        chgTimerQ <= chgTimerQ + TIMER_W'(1);
      if (stateD == charger_state_pkg::ST_OFF || clearWrite || !wdEnQ)
        wdTimerQ <= '0;
      else if (!wdExpired)
        wdTimerQ <= wdTimerQ + TIMER_W'(1);
      if (stateD == charger_state_pkg::ST_TSHDN) begin
        modeQ <= `MODE_DEFAULT;
        wdEnQ <= 1'b0;
        tempEnQ <= 1'b1;
      end else begin
        if (modeWrStrobe && serialEnable) modeQ <= modeWrData;
        if (hostTimerEnWr && serialEnable) wdEnQ <= host_timer_enable;
        if (batteryTempEnWr && serialEnable) tempEnQ <= battery_temp_control_enable;
      end
      if (stateQ == charger_state_pkg::ST_TFAULT) begin
        prevModeOffQ <= prevModeOffQ | modeOffNow;
        pinSeenHighQ <= pinSeenHighQ | battery_disconnect_pin;
      end else begin
        prevModeOffQ <= 1'b0;
        pinSeenHighQ <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      charger_event_flag <= 1'b0;
      charger_good_flag <= 1'b0;
      charger_detail_code <= `DTL_OFF;
      thermistor_detail_code <= 3'h0;
      thermal_regulation_flag <= 1'b0;
      modeField <= `MODE_DEFAULT;
      hostTimerEnabled <= 1'b0;
      battery_temp_control_enable_q <= 1'b1;
      chargeEnable <= 1'b0;
      currentPhase <= 2'h0;
      useCoolSettings <= 1'b0;
      fastCurrentSel <= 8'h0;
      regVoltageTarget <= 16'h0;
      serialEnable <= 1'b1;
      shipMode <= 1'b0;
    end else begin
      // One-cycle pulse; foldback never touches the good flag
      charger_event_flag <= dbEvent || enterFault || stopEvent || foldEdge;
      if (enterFault) begin
        charger_good_flag <= 1'b0;
        charger_detail_code <= `DTL_TFAULT;
      end else if (stateChange && stateD == charger_state_pkg::ST_WDOG) begin
        charger_good_flag <= 1'b0;
        charger_detail_code <= `DTL_WDOG;
      end else if (stateChange && stateD == charger_state_pkg::ST_TSHDN) begin
        charger_good_flag <= 1'b0;
        charger_detail_code <= `DTL_TSHDN;
      end else if (dbUpdate || dbOffUpdate) begin
        charger_good_flag <= dbGood;
        charger_detail_code <= dbCode;
      end
      thermistor_detail_code <= tempEnQ ? tempBand : 3'h0;
      thermal_regulation_flag <= thermalFoldbackActive;
      modeField <= modeQ;
      hostTimerEnabled <= wdEnQ;
      battery_temp_control_enable_q <= tempEnQ;
      chargeEnable <= chargingNext;
      currentPhase <= phase;
      useCoolSettings <= coolBand;
      fastCurrentSel <= coolBand ? cool_band_current_sel : 8'hff;
      regVoltageTarget <= coolBand ? cool_band_voltage_sel :
                          warmBand ? 16'(primary_regulation_voltage_sel - `WARM_DROP_MV) :
                                     primary_regulation_voltage_sel;
      serialEnable <= stateD != charger_state_pkg::ST_SHIP;
      shipMode <= stateD == charger_state_pkg::ST_SHIP;
    end
  end
endmodule

// >>> testbench/charger_state_control_assertions.sv
// Port-level assertion checker for the charger state control block
`timescale 1ns/10ps
module charger_state_control_checker (
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic [15:0] primary_regulation_voltage_sel,
  input wire logic [2:0]  tempBand,
  input wire logic        charger_event_flag,
  input wire logic        charger_good_flag,
  input wire logic [7:0]  charger_detail_code,
  input wire logic [2:0]  thermistor_detail_code,
  input wire logic        thermal_regulation_flag,
  input wire logic [3:0]  modeField,
  input wire logic        battery_temp_control_enable_q,
  input wire logic        chargeEnable,
  input wire logic [15:0] regVoltageTarget,
  input wire logic        serialEnable,
  input wire logic        shipMode
);
  // ----------------------------------------
  // Status and control relations
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  topoff_good_a: assert property (
    charger_detail_code == 8'h03 |-> charger_good_flag) else $error("top-off code, good low");
  done_idle_a: assert property (
    $rose(charger_detail_code == 8'h04) |-> !charger_good_flag && !chargeEnable)
    else $error("done code with charger active");
  fault_event_a: assert property (
    $rose(charger_detail_code == 8'h06) |-> (!charger_good_flag ##[0:1] charger_event_flag))
    else $error("timer fault entry wrong");
  shutdown_off_a: assert property (
    $rose(charger_detail_code == 8'h0a) |-> ##[0:2] (!chargeEnable && modeField == 4'h5))
    else $error("shutdown left charger or mode");
  foldback_event_a: assert property (
    $changed(thermal_regulation_flag) |-> ##[0:1] charger_event_flag)
    else $error("foldback edge without event");
  band_report_a: assert property (
    (battery_temp_control_enable_q && $stable(tempBand)) [*2] |-> thermistor_detail_code == tempBand)
    else $error("thermistor code mismatch");
  warm_drop_a: assert property (
    (tempBand == 3'd3 && $stable(primary_regulation_voltage_sel)) [*3]
    |-> regVoltageTarget == primary_regulation_voltage_sel - 16'h00b4)
    else $error("warm voltage target wrong");
  cold_hot_a: assert property (
    ((tempBand == 3'd1 || tempBand == 3'd4) && battery_temp_control_enable_q) [*3] |-> !chargeEnable)
    else $error("charging outside band");
  ship_entry_a: assert property (
    $rose(shipMode) |-> !serialEnable) else $error("serial alive in ship mode");
  ship_exit_a: assert property (
    $fell(shipMode) |-> serialEnable) else $error("serial dead after ship mode");
endmodule

bind charger_state_control charger_state_control_checker chk (.clock, .arst_n,
  .primary_regulation_voltage_sel, .tempBand, .charger_event_flag, .charger_good_flag,
  .charger_detail_code, .thermistor_detail_code, .thermal_regulation_flag, .modeField,
  .battery_temp_control_enable_q, .chargeEnable, .regVoltageTarget, .serialEnable, .shipMode);

// >>> testbench/host_watchdog_model.sv
// Host processor model that services the charger watchdog
`timescale 1ns/10ps
module host_watchdog_model #(
  parameter int unsigned PERIOD = 60
) (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       serviceOn,
  output logic [1:0]      host_timer_clear,
  output logic            hostTimerClrWr
);
  logic [15:0] count_q;

  // Idle data is a non-clear code so only the strobe qualifies a write
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count_q          <= 16'h0000;
      hostTimerClrWr   <= 1'b0;
      host_timer_clear <= 2'h2;
    end else begin
      hostTimerClrWr   <= 1'b0;
      host_timer_clear <= 2'h2;
      count_q          <= serviceOn ? count_q + 16'h0001 : 16'h0000;
      if (serviceOn && count_q == 16'(PERIOD)) begin
        count_q          <= 16'h0000;
        hostTimerClrWr   <= 1'b1;
        host_timer_clear <= 2'h1;
      end
    end
  end
endmodule

// >>> testbench/test_charger_state_control.sv
// Self-checking bench for the charger state control block
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module test_charger_state_control;
  logic        clock, arst_n, inputValid, modeWrStrobe, battery_disconnect_pin, serviceOn;
  logic        ship_mode_request, host_timer_enable, hostTimerEnWr, hostTimerClrWr;
  logic        prequal_phase_enable, battery_temp_control_enable, batteryTempEnWr;
  logic        vbatBelowPrechg, vbatBelowSysMin, vbatAboveReg, vbatBelowRestart;
  logic        currentBelowTopoff, tjOverShutdown, tjBelowHysteresis, thermalFoldbackActive;
  logic        charger_event_flag, charger_good_flag, thermal_regulation_flag, hostTimerEnabled;
  logic        battery_temp_control_enable_q, chargeEnable, useCoolSettings, serialEnable, shipMode;
  logic [1:0]  host_timer_clear, currentPhase;
  logic [2:0]  fast_charge_time_limit_sel, topoff_duration_sel, tempBand, thermistor_detail_code;
  logic [3:0]  modeWrData, modeField;
  logic [7:0]  cool_band_current_sel, charger_detail_code, fastCurrentSel;
  logic [15:0] primary_regulation_voltage_sel, cool_band_voltage_sel, regVoltageTarget;
  int          failures, comparisons;

  // Short counts keep the run small; the fixed ticks and the 400-cycle poll in wait_code are sized to these
  charger_state_control #(.PQ_CYCLES(200), .FC_UNIT(100), .TO_UNIT(50), .WD_CYCLES(150),
    .DEBOUNCE_CYC(20)) uut (.clock, .arst_n, .inputValid, .modeWrData, .modeWrStrobe,
    .battery_disconnect_pin, .ship_mode_request, .host_timer_enable, .hostTimerEnWr,
    .host_timer_clear, .hostTimerClrWr, .prequal_phase_enable, .battery_temp_control_enable,
    .batteryTempEnWr, .fast_charge_time_limit_sel, .topoff_duration_sel, .cool_band_current_sel,
    .primary_regulation_voltage_sel, .cool_band_voltage_sel, .vbatBelowPrechg, .vbatBelowSysMin,
    .vbatAboveReg, .vbatBelowRestart, .currentBelowTopoff, .tjOverShutdown, .tjBelowHysteresis,
    .thermalFoldbackActive, .tempBand, .charger_event_flag, .charger_good_flag,
    .charger_detail_code, .thermistor_detail_code, .thermal_regulation_flag, .modeField,
    .hostTimerEnabled, .battery_temp_control_enable_q, .chargeEnable, .currentPhase,
    .useCoolSettings, .fastCurrentSel, .regVoltageTarget, .serialEnable, .shipMode);
  host_watchdog_model #(.PERIOD(60)) host (.clock, .arst_n, .serviceOn, .host_timer_clear,
    .hostTimerClrWr);

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wait_code(input logic [7:0] code, input logic good);
    int i;
    i = 0;
    while (charger_detail_code !== code && i < 400) begin
      tick(1);
      i++;
    end
    `CHK(charger_detail_code, code)
    `CHK(charger_good_flag, good)
  endtask
  task automatic stop_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset;
    `CHK(modeField, 4'h5)
    `CHK(hostTimerEnabled, 1'b0)
    `CHK(battery_temp_control_enable_q, 1'b1)
    `CHK(charger_good_flag, 1'b0)
    tick(25);
    wait_code(8'h08, 1'b1);
    $display("reset test done");
  endtask
  task automatic test_charge;
    @(posedge clock); inputValid <= 1; vbatBelowPrechg <= 1; vbatBelowSysMin <= 1;
    wait_code(8'h00, 1'b1);
    `CHK(currentPhase, 2'h0)
    @(posedge clock); vbatBelowPrechg <= 0;
    tick(5); `CHK(currentPhase, 2'h1)
    @(posedge clock); prequal_phase_enable <= 0;
    wait_code(8'h01, 1'b1);
    `CHK(currentPhase, 2'h1)
    @(posedge clock); vbatBelowSysMin <= 0; prequal_phase_enable <= 1;
    tick(3); `CHK(currentPhase, 2'h2)
    @(posedge clock); vbatAboveReg <= 1;
    wait_code(8'h02, 1'b1);
    @(posedge clock); currentBelowTopoff <= 1;
    wait_code(8'h03, 1'b1);
    @(posedge clock); vbatBelowRestart <= 1; vbatAboveReg <= 0; currentBelowTopoff <= 0;
    wait_code(8'h01, 1'b1);
    @(posedge clock); vbatBelowRestart <= 0; vbatAboveReg <= 1;
    wait_code(8'h02, 1'b1);
    @(posedge clock); currentBelowTopoff <= 1;
    wait_code(8'h03, 1'b1);
    wait_code(8'h04, 1'b0);
    `CHK(chargeEnable, 1'b0)
    $display("charge test done");
  endtask
  task automatic test_watchdog;
    @(posedge clock); host_timer_enable <= 1; hostTimerEnWr <= 1; serviceOn <= 1;
    @(posedge clock); hostTimerEnWr <= 0;
    tick(400); `CHK(charger_detail_code, 8'h04)
    `CHK(hostTimerEnabled, 1'b1)
    @(posedge clock); serviceOn <= 0;
    wait_code(8'h07, 1'b0);
    `CHK(chargeEnable, 1'b0)
    @(posedge clock); serviceOn <= 1;
    tick(100); `CHK(charger_detail_code == 8'h07, 1'b0)
    @(posedge clock); host_timer_enable <= 0; hostTimerEnWr <= 1;
    @(posedge clock); hostTimerEnWr <= 0; serviceOn <= 0;
    $display("watchdog test done");
  endtask
  task automatic test_fault;
    @(posedge clock); fast_charge_time_limit_sel <= 3'h0; vbatBelowRestart <= 1;
    vbatAboveReg <= 0; currentBelowTopoff <= 0;
    wait_code(8'h06, 1'b0);
    tick(60); `CHK(charger_detail_code, 8'h06)
    @(posedge clock); fast_charge_time_limit_sel <= 3'h7; battery_disconnect_pin <= 1;
    @(posedge clock); battery_disconnect_pin <= 0; vbatBelowRestart <= 0;
    tick(30); `CHK(charger_detail_code == 8'h06, 1'b0)
    $display("timer fault test done");
  endtask
  task automatic test_thermal;
    @(posedge clock); modeWrData <= 4'h4; modeWrStrobe <= 1;
    @(posedge clock); modeWrStrobe <= 0; tjOverShutdown <= 1; tjBelowHysteresis <= 0;
    wait_code(8'h0a, 1'b0);
    tick(3); `CHK(modeField, 4'h5)
    @(posedge clock); tjOverShutdown <= 0;
    tick(50); `CHK(charger_detail_code, 8'h0a)
    @(posedge clock); tjBelowHysteresis <= 1;
    tick(60); `CHK(charger_detail_code == 8'h0a, 1'b0)
    @(posedge clock); thermalFoldbackActive <= 1;
    tick(3); `CHK(thermal_regulation_flag, 1'b1)
    $display("thermal test done");
  endtask
  task automatic test_bands;
    @(posedge clock); tempBand <= 3'd3;
    tick(5); `CHK(regVoltageTarget, 16'h20d0 - 16'h00b4)
    `CHK(thermistor_detail_code, 3'd3)
    @(posedge clock); tempBand <= 3'd2; cool_band_voltage_sel <= 16'h1f40;
    tick(5); `CHK(fastCurrentSel, 8'h3c)
    `CHK(regVoltageTarget, 16'h1f40)
    `CHK(useCoolSettings, 1'b1)
    @(posedge clock); tempBand <= 3'd4;
    tick(5); `CHK(chargeEnable, 1'b0)
    @(posedge clock); battery_temp_control_enable <= 0; batteryTempEnWr <= 1;
    @(posedge clock); batteryTempEnWr <= 0;
    tick(3); `CHK(thermistor_detail_code, 3'd0)
    @(posedge clock); tempBand <= 3'd0; thermalFoldbackActive <= 0;
    tick(3); `CHK(thermal_regulation_flag, 1'b0)
    $display("band test done");
  endtask
  task automatic test_ship;
    @(posedge clock); inputValid <= 0; ship_mode_request <= 1;
    tick(5); `CHK(shipMode, 1'b1)
    `CHK(serialEnable, 1'b0)
    @(posedge clock); inputValid <= 1; ship_mode_request <= 0;
    tick(5); `CHK(shipMode, 1'b0)
    `CHK(serialEnable, 1'b1)
    $display("ship test done");
  endtask

  initial begin
    {arst_n, inputValid, modeWrStrobe, battery_disconnect_pin, serviceOn, ship_mode_request} = '0;
    {host_timer_enable, hostTimerEnWr, batteryTempEnWr, vbatBelowPrechg, vbatBelowSysMin} = '0;
    {vbatAboveReg, vbatBelowRestart, currentBelowTopoff, tjOverShutdown} = '0;
    {thermalFoldbackActive, tempBand, modeWrData} = '0;
    {prequal_phase_enable, battery_temp_control_enable, tjBelowHysteresis} = 3'h7;
    fast_charge_time_limit_sel = 3'h7;
    topoff_duration_sel = 3'h1;
    cool_band_current_sel = 8'h3c;
    primary_regulation_voltage_sel = 16'h20d0;
    cool_band_voltage_sel = 16'h2000;
    failures = 0;
    comparisons = 0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    tick(1);
    test_reset();
    test_charge();
    test_watchdog();
    test_fault();
    test_thermal();
    test_bands();
    test_ship();
    stop_test();
  end

  // Generous bound over the longest path of all scenarios
  initial begin
    #(50 * 20000);
    failures++;
    stop_test();
  end
endmodule
